// ==== rtl/slg_cfg.svh ====
// Purpose: Offsets, field positions and reset values of the screen/palette/pin registers
// Assumes: Byte-wide register access at the host address
// Notes:   Definitions only
`ifndef SLG_CFG_SVH
`define SLG_CFG_SVH
// ====================================================
// Register offsets (17-bit host byte address)
`define SLG_OFF_SCREEN1_START_LOW  17'h1FFEC
`define SLG_OFF_SCREEN1_START_HIGH 17'h1FFED
`define SLG_OFF_SCREEN2_START_LOW  17'h1FFEE
`define SLG_OFF_SCREEN2_START_HIGH 17'h1FFEF
`define SLG_OFF_LINE_WORD_OFFSET   17'h1FFF1
`define SLG_OFF_SCREEN1_HEIGHT_LOW 17'h1FFF2
`define SLG_OFF_SCREEN1_HEIGHT_HIGH 17'h1FFF3
`define SLG_OFF_PALETTE_INDEX      17'h1FFF5
`define SLG_OFF_PALETTE_DATA_PORT  17'h1FFF7
`define SLG_OFF_PIN_DIRECTION      17'h1FFF8
`define SLG_OFF_PIN_LEVEL          17'h1FFF9
`define SLG_OFF_SCRATCH_BYTE       17'h1FFFA
// ====================================================
// Field layout
`define SLG_PIN_MASK               5'h1D
`define SLG_PIN_PANEL_MASK         5'h1C
`define SLG_PIN_SAVE_MASK          5'h01
`define SLG_HEIGHT_HIGH_MASK       8'h03
`define SLG_PAL_DATA_LSB           4
`define SLG_NARROW_MASK            4'h7
// ====================================================
// Reset values
`define SLG_RST_BYTE               8'h00
`define SLG_RST_PINS               5'h00
`endif

// ==== rtl/slg_pkg.sv ====
// Purpose: Types of the screen/palette/pin register block
// Assumes: Included header holds all numbers
// Notes:   Types only
package slg_pkg;
    // ====================================================
    // Palette component pointer
    typedef enum logic [1:0] {
        SLG_RED,
        SLG_GREEN,
        SLG_BLUE
    } slg_comp_e;

    // ====================================================
    // Host access bundle
    typedef struct packed {
        logic        sel;
        logic        wr;
        logic [16:0] addr;
        logic [7:0]  wdata;
    } slg_req_s;

    // Display fetch geometry
    typedef struct packed {
        logic [15:0] screen1Start;
        logic [15:0] screen2Start;
        logic [7:0]  lineOffset;
        logic [9:0]  screen1Height;
    } slg_geom_s;

    typedef logic [3:0] slg_nib_t;
endpackage

// ==== rtl/slg_palette_bank.sv ====
// Purpose: One 256 x 4 colour table, flip-flop storage
// Assumes: One write port, two read ports (host and pixel)
// Notes:   Instantiated once per colour
`timescale 1ns/10ps
module slg_palette_bank
    import slg_pkg::*;
(
    // Clock
    input  wire logic     mclk,
    // Write
    input  wire logic     wrEn,
    input  wire logic [7:0] wrIdx,
    input  wire slg_nib_t wrData,
    // Reads
    input  wire logic [7:0] hostIdx,
    output      slg_nib_t hostData,
    input  wire logic [7:0] pixIdx,
    output      slg_nib_t pixData
);
    // ====================================================
    // Storage
    typedef struct packed {
        slg_nib_t [255:0] ent;
    } slg_bank_s;

    slg_bank_s stReg;
    slg_bank_s stNext;

    // Table contents are not reset; software loads them
    always_comb begin
        stNext = stReg;
        if (wrEn) begin
            stNext.ent[wrIdx] = wrData;
        end
    end

    always_ff @(posedge mclk) begin
        stReg <= stNext;
    end

    assign hostData = stReg.ent[hostIdx];
    assign pixData  = stReg.ent[pixIdx];
endmodule

// ==== rtl/slg_regs.sv ====
// Purpose: Screen geometry, palette port, general pins and scratch registers
// Assumes: Single-cycle byte host access; pins are asynchronous
// Notes:   Read data registered one cycle after the access cycle
`timescale 1ns/10ps
`include "slg_cfg.svh"

// Behaviour
// - Screen two start word address is built from a low and high byte.
// - An 8-bit word offset is added between consecutive display lines.
// - A nonzero offset makes a virtual image; zero gives contiguous lines.
// - Screen one height is 10 bits: a low byte plus two high bits.
// - Lines 0..n show screen one, n+1 onward show screen two when n < panelLines.
// - Three 256-entry 4-bit tables for red, green and blue.
// - Writing the index register sets the pointer and selects red.
// - Each data port access steps red, green, blue, then next red.
// - Table value sits in data bits 7..4; bits 3..0 are unused.
// - With the 9-bit panel only the three low entry bits are output.
// - Red and green are staged; the entry commits on the blue write.
// - Direction bits for pins 4,3,2,0; zero input, one output.
// - An input pin reads its current level in the level register.
// - An output pin drives the value written to its level bit.
// - Pin zero direction is ignored while hardware power saving is on.
// - Pins 4..2 direction is ignored when the 12-bit panel is selected.
// - An 8-bit scratch byte reads back and steers nothing.
// - Screen one start word address comes from a low and high byte.
module slg_regs
    import slg_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // Host register access
    input  wire slg_req_s    hostReq,
    output      logic [7:0]  rdData,
    output      logic        rdValid,
    // Panel configuration inputs
    input  wire logic        panelWide,
    input  wire logic        hwSaveEn,
    input  wire logic [9:0]  panelLines,
    // Fetch sequencing
    input  wire logic        frameStart,
    input  wire logic        lineStart,
    input  wire logic [7:0]  lineWords,
    output      logic [15:0] lineAddr,
    output      logic        inScreen2,
    // Pixel colour path
    input  wire logic [7:0]  pixIdx,
    output      logic [11:0] pixRgb,
    // General pins
    input  wire logic [4:0]  pinIn,
    output      logic [4:0]  pinOut,
    output      logic [4:0]  pinOe
);
    // ====================================================
    // State
    typedef struct packed {
        slg_geom_s   geom;
        slg_comp_e   comp;
        logic [7:0]  palIdx;
        slg_nib_t    stageR;
        slg_nib_t    stageG;
        logic [4:0]  pinDir;
        logic [4:0]  pinVal;
        logic [7:0]  scratch;
        logic [4:0]  pinS1;
        logic [4:0]  pinS2;
        logic [7:0]  rdData;
        logic        rdValid;
        logic [9:0]  lineNum;
        logic [15:0] lineAddr;
        logic        inScreen2;
        logic [11:0] pixRgb;
        logic [4:0]  pinOut;
        logic [4:0]  pinOe;
    } slg_state_s;

    slg_state_s stReg;
    slg_state_s stNext;

    logic        palWr;
    slg_nib_t    palRdR;
    slg_nib_t    palRdG;
    slg_nib_t    palRdB;
    slg_nib_t    pixR;
    slg_nib_t    pixG;
    slg_nib_t    pixB;
    slg_nib_t    wrNib;
    logic        acc;
    logic        wrAcc;
    logic        dataAcc;
    logic [4:0]  dirEff;
    logic [15:0] nextLine;

    assign acc     = hostReq.sel;
    assign wrAcc   = acc & hostReq.wr;
    assign dataAcc = acc & (hostReq.addr == `SLG_OFF_PALETTE_DATA_PORT);
    assign wrNib   = hostReq.wdata[7:`SLG_PAL_DATA_LSB];
    // Commit only on the blue write
    assign palWr   = dataAcc & hostReq.wr & (stReg.comp == SLG_BLUE);

    // ====================================================
    // Colour tables
    slg_palette_bank uRed (
        .mclk     (mclk),
        .wrEn     (palWr),
        .wrIdx    (stReg.palIdx),
        .wrData   (stReg.stageR),
        .hostIdx  (stReg.palIdx),
        .hostData (palRdR),
        .pixIdx   (pixIdx),
        .pixData  (pixR)
    );
    slg_palette_bank uGreen (
        .mclk     (mclk),
        .wrEn     (palWr),
        .wrIdx    (stReg.palIdx),
        .wrData   (stReg.stageG),
        .hostIdx  (stReg.palIdx),
        .hostData (palRdG),
        .pixIdx   (pixIdx),
        .pixData  (pixG)
    );
    slg_palette_bank uBlue (
        .mclk     (mclk),
        .wrEn     (palWr),
        .wrIdx    (stReg.palIdx),
        .wrData   (wrNib),
        .hostIdx  (stReg.palIdx),
        .hostData (palRdB),
        .pixIdx   (pixIdx),
        .pixData  (pixB)
    );

    // ====================================================
    // Effective pin direction
    always_comb begin
        dirEff = stReg.pinDir & `SLG_PIN_MASK;
        if (hwSaveEn) begin
            dirEff = dirEff & ~`SLG_PIN_SAVE_MASK;
        end
        if (panelWide) begin
            dirEff = dirEff & ~`SLG_PIN_PANEL_MASK;
        end
    end

    // Offset adds on top of the words fetched for a line
    assign nextLine = stReg.lineAddr + {8'h00, lineWords}
                    + {8'h00, stReg.geom.lineOffset};

    // ====================================================
    // Next state
    always_comb begin
        stNext         = stReg;
        stNext.rdValid = 1'b0;
        stNext.pinS1   = pinIn;
        stNext.pinS2   = stReg.pinS1;

        // Register writes
        if (wrAcc) begin
            unique case (hostReq.addr)
                `SLG_OFF_SCREEN1_START_LOW: begin
                    stNext.geom.screen1Start[7:0] = hostReq.wdata;
                end
                `SLG_OFF_SCREEN1_START_HIGH: begin
                    stNext.geom.screen1Start[15:8] = hostReq.wdata;
                end
                `SLG_OFF_SCREEN2_START_LOW: begin
                    stNext.geom.screen2Start[7:0] = hostReq.wdata;
                end
                `SLG_OFF_SCREEN2_START_HIGH: begin
                    stNext.geom.screen2Start[15:8] = hostReq.wdata;
                end
                `SLG_OFF_LINE_WORD_OFFSET:   stNext.geom.lineOffset = hostReq.wdata;
                `SLG_OFF_SCREEN1_HEIGHT_LOW: begin
                    stNext.geom.screen1Height[7:0] = hostReq.wdata;
                end
                `SLG_OFF_SCREEN1_HEIGHT_HIGH: begin
                    stNext.geom.screen1Height[9:8] = hostReq.wdata[1:0];
                end
                `SLG_OFF_PALETTE_INDEX: begin
                    stNext.palIdx = hostReq.wdata;
                    stNext.comp   = SLG_RED;
                end
                `SLG_OFF_PIN_DIRECTION: begin
                    stNext.pinDir = hostReq.wdata[4:0] & `SLG_PIN_MASK;
                end
                `SLG_OFF_PIN_LEVEL: begin
                    stNext.pinVal = hostReq.wdata[4:0] & `SLG_PIN_MASK;
                end
                `SLG_OFF_SCRATCH_BYTE:       stNext.scratch = hostReq.wdata;
                default:                     stNext.scratch = stReg.scratch;
            endcase
            if (dataAcc && stReg.comp == SLG_RED) begin
                stNext.stageR = wrNib;
            end
            if (dataAcc && stReg.comp == SLG_GREEN) begin
                stNext.stageG = wrNib;
            end
        end

        // Pointer walk on any data port access
        if (dataAcc) begin
            unique case (stReg.comp)
                SLG_RED: begin
                    stNext.comp = SLG_GREEN;
                end
                SLG_GREEN: begin
                    stNext.comp = SLG_BLUE;
                end
                SLG_BLUE: begin
                    stNext.comp   = SLG_RED;
                    stNext.palIdx = stReg.palIdx + 8'h01;
                end
                default: stNext.comp = SLG_RED;
            endcase
        end

        // Register reads
        if (acc && !hostReq.wr) begin
            stNext.rdValid = 1'b1;
            stNext.rdData  = 8'h00;
            unique case (hostReq.addr)
                `SLG_OFF_SCREEN1_START_LOW:   stNext.rdData = stReg.geom.screen1Start[7:0];
                `SLG_OFF_SCREEN1_START_HIGH:  stNext.rdData = stReg.geom.screen1Start[15:8];
                `SLG_OFF_SCREEN2_START_LOW:   stNext.rdData = stReg.geom.screen2Start[7:0];
                `SLG_OFF_SCREEN2_START_HIGH:  stNext.rdData = stReg.geom.screen2Start[15:8];
                `SLG_OFF_LINE_WORD_OFFSET:    stNext.rdData = stReg.geom.lineOffset;
                `SLG_OFF_SCREEN1_HEIGHT_LOW:  stNext.rdData = stReg.geom.screen1Height[7:0];
                `SLG_OFF_SCREEN1_HEIGHT_HIGH: stNext.rdData = {6'h00,
                                                  stReg.geom.screen1Height[9:8]};
                `SLG_OFF_PALETTE_INDEX:       stNext.rdData = stReg.palIdx;
                `SLG_OFF_PALETTE_DATA_PORT: begin
                    unique case (stReg.comp)
                        SLG_RED:   stNext.rdData = {palRdR, 4'h0};
                        SLG_GREEN: stNext.rdData = {palRdG, 4'h0};
                        SLG_BLUE:  stNext.rdData = {palRdB, 4'h0};
                        default:   stNext.rdData = 8'h00;
                    endcase
                end
                `SLG_OFF_PIN_DIRECTION:       stNext.rdData = {3'h0, stReg.pinDir};
                `SLG_OFF_PIN_LEVEL: begin
                    // Input pins show the synchronised pin level
                    stNext.rdData = {3'h0, ((stReg.pinS2 & ~dirEff)
                                          | (stReg.pinVal & dirEff)) & `SLG_PIN_MASK};
                end
                `SLG_OFF_SCRATCH_BYTE:        stNext.rdData = stReg.scratch;
                default:                      stNext.rdData = 8'h00;
            endcase
        end

        // Line fetch address and split boundary
        if (frameStart) begin
            stNext.lineNum   = 10'h000;
            stNext.lineAddr  = stReg.geom.screen1Start;
            stNext.inScreen2 = 1'b0;
        end else if (lineStart) begin
            stNext.lineNum = stReg.lineNum + 10'h001;
            // Split only applies when the height is inside the panel
            if (stReg.lineNum == stReg.geom.screen1Height
                && stReg.geom.screen1Height < panelLines) begin
                stNext.lineAddr  = stReg.geom.screen2Start;
                stNext.inScreen2 = 1'b1;
            end else begin
                stNext.lineAddr = nextLine;
            end
        end

        // Pixel colour; 9-bit panel keeps three bits per colour
        if (panelWide) begin
            stNext.pixRgb = {pixR, pixG, pixB};
        end else begin
            stNext.pixRgb = {pixR & `SLG_NARROW_MASK, pixG & `SLG_NARROW_MASK,
                             pixB & `SLG_NARROW_MASK};
        end

        stNext.pinOe  = dirEff;
        stNext.pinOut = stReg.pinVal & dirEff;
    end

    // ====================================================
    // Registers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            stReg <= '0;
        end else begin
            stReg <= stNext;
        end
    end

    assign rdData    = stReg.rdData;
    assign rdValid   = stReg.rdValid;
    assign lineAddr  = stReg.lineAddr;
    assign inScreen2 = stReg.inScreen2;
    assign pixRgb    = stReg.pixRgb;
    assign pinOut    = stReg.pinOut;
    assign pinOe     = stReg.pinOe;

    // ====================================================
    // Checks
    sequence s_idxWrite;
        hostReq.sel && hostReq.wr && hostReq.addr == `SLG_OFF_PALETTE_INDEX;
    endsequence
    sequence s_dataAcc;
        hostReq.sel && hostReq.addr == `SLG_OFF_PALETTE_DATA_PORT;
    endsequence

    property p_idxRed;
        @(posedge mclk) disable iff (!rst_n)
        s_idxWrite |=> stReg.comp == SLG_RED && stReg.palIdx == $past(hostReq.wdata);
    endproperty
    a_idxRed: assert property (p_idxRed) else $error("index write not red");

    property p_blueWrap;
        @(posedge mclk) disable iff (!rst_n)
        (s_dataAcc and stReg.comp == SLG_BLUE)
            |=> stReg.comp == SLG_RED && stReg.palIdx == $past(stReg.palIdx) + 8'h01;
    endproperty
    a_blueWrap: assert property (p_blueWrap) else $error("blue step wrong");

    property p_redGreen;
        @(posedge mclk) disable iff (!rst_n)
        (s_dataAcc and stReg.comp == SLG_RED) |=> stReg.comp == SLG_GREEN;
    endproperty
    a_redGreen: assert property (p_redGreen) else $error("red step wrong");

    property p_noEarlyCommit;
        @(posedge mclk) disable iff (!rst_n)
        (s_dataAcc and hostReq.wr && stReg.comp != SLG_BLUE) |-> !palWr;
    endproperty
    a_noEarlyCommit: assert property (p_noEarlyCommit) else $error("early commit");

    property p_saveDir;
        @(posedge mclk) disable iff (!rst_n)
        hwSaveEn |=> !pinOe[0];
    endproperty
    a_saveDir: assert property (p_saveDir) else $error("pin zero driven");

    property p_wideDir;
        @(posedge mclk) disable iff (!rst_n)
        panelWide |=> pinOe[4:2] == 3'h0;
    endproperty
    a_wideDir: assert property (p_wideDir) else $error("panel pins driven");

    property p_narrow;
        @(posedge mclk) disable iff (!rst_n)
        !panelWide |=> pixRgb[3] == 1'b0 && pixRgb[7] == 1'b0 && pixRgb[11] == 1'b0;
    endproperty
    a_narrow: assert property (p_narrow) else $error("wide bits on narrow panel");

    property p_scratch;
        @(posedge mclk) disable iff (!rst_n)
        (hostReq.sel && hostReq.wr && hostReq.addr == `SLG_OFF_SCRATCH_BYTE)
            ##1 (hostReq.sel && !hostReq.wr && hostReq.addr == `SLG_OFF_SCRATCH_BYTE)
            |=> rdValid && rdData == $past(hostReq.wdata, 2);
    endproperty
    a_scratch: assert property (p_scratch) else $error("scratch readback");

    property p_split;
        @(posedge mclk) disable iff (!rst_n)
        (lineStart && !frameStart && stReg.lineNum == stReg.geom.screen1Height
         && stReg.geom.screen1Height < panelLines)
            |=> inScreen2 && lineAddr == $past(stReg.geom.screen2Start);
    endproperty
    a_split: assert property (p_split) else $error("split missed");
endmodule

// ==== sim/slg_regs_tb_top.sv ====
// Purpose: Self-checking bench for the screen/palette/pin register block
// Assumes: Offsets from slg_cfg.svh; bench drives every port itself
// Notes:   Inputs change on the falling edge only
`timescale 1ns/10ps
`include "slg_cfg.svh"
module slg_regs_tb_top
    import slg_pkg::*;
;
    // ====================================================
    // Signals
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    slg_req_s    req;
    logic [7:0]  rdData;
    logic        rdValid;
    logic        panelWide;
    logic        hwSaveEn;
    logic [9:0]  panelLines;
    logic        frameStart;
    logic        lineStart;
    logic [7:0]  lineWords;
    logic [15:0] lineAddr;
    logic        inScreen2;
    logic [7:0]  pixIdx;
    logic [11:0] pixRgb;
    logic [4:0]  pinIn;
    logic [4:0]  pinOut;
    logic [4:0]  pinOe;
    int          num_errors = 0;
    int          n_checks = 0;

    always #5 mclk = ~mclk;

    slg_regs i_slg_regs (
        .mclk(mclk), .rst_n(rst_n), .hostReq(req), .rdData(rdData), .rdValid(rdValid),
        .panelWide(panelWide), .hwSaveEn(hwSaveEn), .panelLines(panelLines),
        .frameStart(frameStart), .lineStart(lineStart), .lineWords(lineWords),
        .lineAddr(lineAddr), .inScreen2(inScreen2), .pixIdx(pixIdx), .pixRgb(pixRgb),
        .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe)
    );

    // ====================================================
    // Shared tasks
    task automatic results();
        $display("checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [16:0] a, input logic [7:0] d);
        @(negedge mclk);
        req = '{sel: 1'b1, wr: 1'b1, addr: a, wdata: d};
        @(negedge mclk);
        req.sel = 1'b0;
    endtask

    // Bounded wait for the read answer
    task automatic rdc(input logic [16:0] a, input logic [7:0] exp);
        int i;
        @(negedge mclk);
        req = '{sel: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(negedge mclk);
        req.sel = 1'b0;
        for (i = 0; i < 4 && rdValid !== 1'b1; i++) @(negedge mclk);
        if (rdValid !== 1'b1) begin
            num_errors++;
            results();
        end else begin
            chk({8'h00, rdData}, {8'h00, exp});
        end
    endtask

    task automatic pulse(input logic frame);
        @(negedge mclk);
        frameStart = frame;
        lineStart  = !frame;
        @(negedge mclk);
        frameStart = 1'b0;
        lineStart  = 1'b0;
    endtask

    // Colour output is registered; sample two cycles after setting the index
    task automatic pix(input logic [7:0] idx, input logic [11:0] exp);
        @(negedge mclk);
        pixIdx = idx;
        repeat (2) @(negedge mclk);
        chk({4'h0, pixRgb}, {4'h0, exp});
    endtask

    // ====================================================
    // Scenarios
    task automatic t_scratch();
        wr(`SLG_OFF_SCRATCH_BYTE, 8'h5A);
        rdc(`SLG_OFF_SCRATCH_BYTE, 8'h5A);
        wr(17'h1FFF6, 8'hFF);
        rdc(17'h1FFF6, 8'h00);
        rdc(`SLG_OFF_SCRATCH_BYTE, 8'h5A);
        // Back-to-back write then read, no idle cycle
        @(negedge mclk);
        req = '{sel: 1'b1, wr: 1'b1, addr: `SLG_OFF_SCRATCH_BYTE, wdata: 8'hC3};
        @(negedge mclk);
        req = '{sel: 1'b1, wr: 1'b0, addr: `SLG_OFF_SCRATCH_BYTE, wdata: 8'h00};
        @(negedge mclk);
        req.sel = 1'b0;
        chk({15'h0000, rdValid}, 16'h0001);
        chk({8'h00, rdData}, 16'h00C3);
        @(negedge mclk);
        chk({15'h0000, rdValid}, 16'h0000);
    endtask

    task automatic t_geom();
        wr(`SLG_OFF_SCREEN1_START_LOW, 8'h34);
        wr(`SLG_OFF_SCREEN1_START_HIGH, 8'h12);
        wr(`SLG_OFF_SCREEN2_START_LOW, 8'hCD);
        wr(`SLG_OFF_SCREEN2_START_HIGH, 8'hAB);
        wr(`SLG_OFF_LINE_WORD_OFFSET, 8'h10);
        wr(`SLG_OFF_SCREEN1_HEIGHT_LOW, 8'h01);
        wr(`SLG_OFF_SCREEN1_HEIGHT_HIGH, 8'hFC);
        rdc(`SLG_OFF_SCREEN1_HEIGHT_HIGH, 8'h00);
        rdc(`SLG_OFF_SCREEN2_START_HIGH, 8'hAB);
        pulse(1'b1);
        chk(lineAddr, 16'h1234);
        chk({15'h0000, inScreen2}, 16'h0000);
        pulse(1'b0);
        chk(lineAddr, 16'h126C);
        pulse(1'b0);
        chk(lineAddr, 16'hABCD);
        chk({15'h0000, inScreen2}, 16'h0001);
        pulse(1'b0);
        chk(lineAddr, 16'hAC05);
        wr(`SLG_OFF_LINE_WORD_OFFSET, 8'h00);
        pulse(1'b0);
        chk(lineAddr, 16'hAC2D);
        wr(`SLG_OFF_SCREEN1_HEIGHT_HIGH, 8'hFF);
        rdc(`SLG_OFF_SCREEN1_HEIGHT_HIGH, 8'h03);
    endtask

    task automatic t_palette();
        wr(`SLG_OFF_PALETTE_INDEX, 8'h03);
        wr(`SLG_OFF_PALETTE_DATA_PORT, 8'hA0);
        wr(`SLG_OFF_PALETTE_DATA_PORT, 8'hB0);
        wr(`SLG_OFF_PALETTE_DATA_PORT, 8'hC0);
        pix(8'h03, 12'hABC);
        wr(`SLG_OFF_PALETTE_DATA_PORT, 8'h57);
        wr(`SLG_OFF_PALETTE_DATA_PORT, 8'h65);
        wr(`SLG_OFF_PALETTE_DATA_PORT, 8'h7F);
        pix(8'h04, 12'h567);
        wr(`SLG_OFF_PALETTE_INDEX, 8'h03);
        wr(`SLG_OFF_PALETTE_DATA_PORT, 8'h10);
        wr(`SLG_OFF_PALETTE_DATA_PORT, 8'h20);
        pix(8'h03, 12'hABC);
        wr(`SLG_OFF_PALETTE_DATA_PORT, 8'h30);
        pix(8'h03, 12'h123);
        wr(`SLG_OFF_PALETTE_INDEX, 8'h04);
        rdc(`SLG_OFF_PALETTE_DATA_PORT, 8'h50);
        rdc(`SLG_OFF_PALETTE_DATA_PORT, 8'h60);
        rdc(`SLG_OFF_PALETTE_DATA_PORT, 8'h70);
        wr(`SLG_OFF_PALETTE_DATA_PORT, 8'hF0);
        wr(`SLG_OFF_PALETTE_DATA_PORT, 8'hE0);
        wr(`SLG_OFF_PALETTE_DATA_PORT, 8'hD0);
        pix(8'h05, 12'hFED);
        panelWide = 1'b0;
        pix(8'h05, 12'h765);
        panelWide = 1'b1;
    endtask

    task automatic t_pins();
        panelWide = 1'b0;
        wr(`SLG_OFF_PIN_DIRECTION, 8'h1F);
        rdc(`SLG_OFF_PIN_DIRECTION, 8'h1D);
        wr(`SLG_OFF_PIN_LEVEL, 8'h1F);
        rdc(`SLG_OFF_PIN_LEVEL, 8'h1D);
        chk({11'h000, pinOe}, 16'h001D);
        chk({11'h000, pinOut}, 16'h001D);
        hwSaveEn = 1'b1;
        repeat (2) @(negedge mclk);
        chk({11'h000, pinOe}, 16'h001C);
        panelWide = 1'b1;
        repeat (2) @(negedge mclk);
        chk({11'h000, pinOe}, 16'h0000);
        hwSaveEn  = 1'b0;
        panelWide = 1'b0;
        wr(`SLG_OFF_PIN_DIRECTION, 8'h00);
        pinIn = 5'h0A;
        repeat (4) @(negedge mclk);
        rdc(`SLG_OFF_PIN_LEVEL, 8'h08);
        chk({11'h000, pinOe}, 16'h0000);
    endtask

    // ====================================================
    // Main sequence
    initial begin
        req        = '0;
        panelWide  = 1'b1;
        hwSaveEn   = 1'b0;
        panelLines = 10'h003;
        frameStart = 1'b0;
        lineStart  = 1'b0;
        lineWords  = 8'h28;
        pixIdx     = 8'h00;
        pinIn      = 5'h00;
        repeat (3) @(negedge mclk);
        rst_n = 1'b1;
        t_scratch();
        t_geom();
        t_palette();
        t_pins();
        results();
    end
endmodule
